// ---- tuc_pkg.sv ----
// constants for the up/down reload timer with clock output
package tuc_pkg;

    // register bus widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_MODE = 4'h1;
    localparam logic [3:0] OFS_CNT_LO = 4'h2;
    localparam logic [3:0] OFS_CNT_HI = 4'h3;
    localparam logic [3:0] OFS_RLD_LO = 4'h4;
    localparam logic [3:0] OFS_RLD_HI = 4'h5;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h6;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h7;

    // timer_control_reg fields
    localparam int BIT_OVF = 7;
    localparam int BIT_EXT = 6;
    localparam int BIT_RXB = 5;
    localparam int BIT_TXB = 4;
    localparam int BIT_RUN = 2;
    localparam int BIT_SRC = 1;

    // timer_mode_reg fields
    localparam int BIT_CKO = 1;
    localparam int BIT_UPD = 0;

    // interrupt status fields
    localparam int BIT_IRQ_OVF = 0;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] RLD_RST = 16'h0000;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;

    // timing
    localparam int CLK_HZ = 40000000;
    localparam int TIMER_DIV = 6;
    localparam int CKO_DIV = 2;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;

endpackage : tuc_pkg

// ---- tuc_timer.sv ----
// 16-bit up/down reload timer with programmable clock output
//
// What this block does
// - count held as low and high byte, carrying
// - source select: clock/6 or count pin edges
// - count only while run bit set
// - up/down enable takes direction from pin
// - pin high: count up, flag and interrupt
// - up overflow loads reload pair
// - pin low: down, underflow at reload, load FFFFh
// - toggle flag flips on wrap, no interrupt
// - clock-out mode gives 50% duty clock
// - clock-out wraps reload, raise no interrupt
// - output rate is clock/(4*(65536-reload))
// - clock-out drives the count pin
// - baud and clock-out share reload pair
// - hardware sets overflow flag, software clears
`timescale 1ns/1ps

module tuc_timer #(
    parameter int TIMER_DIV = tuc_pkg::TIMER_DIV,
    parameter int CKO_DIV = tuc_pkg::CKO_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [tuc_pkg::ADDR_W-1:0] addr,
    input wire logic [tuc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [tuc_pkg::DATA_W-1:0] rdata,
    // count / clock-out pin
    input wire logic count_clockout_pin_in,
    output logic count_clockout_pin_out,
    output logic count_clockout_pin_oe,
    // direction pin
    input wire logic direction_pin,
    // events
    output logic irq,
    output logic baud_tick
);

    // register state
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic overflow_flag;
    logic external_toggle_flag;
    logic run_bit;
    logic count_source_select;
    logic rx_baud;
    logic tx_baud;
    logic clockout_enable;
    logic updown_enable;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic cko_level;

    // dividers
    logic [2:0] div_cnt;
    logic [1:0] cko_cnt;

    // pin synchronisers
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic pin_level;
    logic dir_s1;
    logic dir_s2;
    logic dir_s3;
    logic dir_level;

    // address decode
    wire sel_ctrl = addr == tuc_pkg::OFS_CTRL;
    wire sel_mode = addr == tuc_pkg::OFS_MODE;
    wire sel_cnt_lo = addr == tuc_pkg::OFS_CNT_LO;
    wire sel_cnt_hi = addr == tuc_pkg::OFS_CNT_HI;
    wire sel_rld_lo = addr == tuc_pkg::OFS_RLD_LO;
    wire sel_rld_hi = addr == tuc_pkg::OFS_RLD_HI;
    wire sel_stat = addr == tuc_pkg::OFS_IRQ_STAT;
    wire sel_mask = addr == tuc_pkg::OFS_IRQ_MASK;
    wire wr_ctrl = wr & sel_ctrl;
    wire wr_mode = wr & sel_mode;
    wire wr_cnt_lo = wr & sel_cnt_lo;
    wire wr_cnt_hi = wr & sel_cnt_hi;
    wire wr_rld_lo = wr & sel_rld_lo;
    wire wr_rld_hi = wr & sel_rld_hi;
    wire wr_stat = wr & sel_stat;
    wire wr_mask = wr & sel_mask;
    wire any_wr = wr;

    // tick sources
    wire div6_tick = div_cnt == 3'(TIMER_DIV - 1);
    wire div2_tick = cko_cnt == 2'(CKO_DIV - 1);
    wire pin_agree = pin_s2 == pin_s3;
    wire pin_fall = pin_agree & ~pin_s3 & pin_level;
    wire dir_agree = dir_s2 == dir_s3;

    // count path
    wire [15:0] cnt = {count_high_byte, count_low_byte};
    wire [15:0] reload = {reload_high_byte, reload_low_byte};
    wire baud_mode = rx_baud | tx_baud;
    wire ext_src = count_source_select & ~clockout_enable;
    wire tick_in = clockout_enable ? div2_tick
                 : (ext_src ? pin_fall : div6_tick);
    wire step = run_bit & tick_in;
    wire updown_mode = updown_enable & ~clockout_enable
                     & ~baud_mode;
    wire count_down = updown_mode & ~dir_level;
    wire at_top = cnt == tuc_pkg::CNT_MAX;
    wire at_floor = cnt == reload;
    wire wrap = step & (count_down ? at_floor : at_top);
    wire [15:0] cnt_inc = cnt + tuc_pkg::CNT_ONE;
    wire [15:0] cnt_dec = cnt - tuc_pkg::CNT_ONE;
    wire [15:0] cnt_wrap = count_down ? tuc_pkg::CNT_MAX
                         : reload;
    wire [15:0] cnt_step = count_down ? cnt_dec : cnt_inc;
    wire [15:0] next_cnt = !step ? cnt
                         : (wrap ? cnt_wrap : cnt_step);
    // no flag in clock-out or baud use
    wire flag_event = wrap & ~clockout_enable
                    & ~baud_mode;
    wire toggle_event = wrap & updown_mode;
    wire cko_event = wrap & clockout_enable;

    // next register values
    wire [7:0] next_lo = wr_cnt_lo ? wdata : next_cnt[7:0];
    wire [7:0] next_hi = wr_cnt_hi ? wdata : next_cnt[15:8];
    wire next_ovf = flag_event
                  | (wr_ctrl ? wdata[tuc_pkg::BIT_OVF]
                             : overflow_flag);
    wire next_ext = toggle_event ? ~external_toggle_flag
                  : (wr_ctrl ? wdata[tuc_pkg::BIT_EXT]
                             : external_toggle_flag);
    wire [7:0] irq_events = {7'h00, flag_event};
    wire [7:0] irq_clear = wr_stat ? wdata : 8'h00;
    wire [7:0] next_stat = (irq_stat & ~irq_clear) | irq_events;

    // read mux
    wire [7:0] ctrl_view = {overflow_flag, external_toggle_flag,
                            rx_baud, tx_baud, 1'b0, run_bit,
                            count_source_select, 1'b0};
    wire [7:0] mode_view = {6'h00, clockout_enable, updown_enable};
    wire [7:0] read_mux = sel_ctrl ? ctrl_view
                        : sel_mode ? mode_view
                        : sel_cnt_lo ? count_low_byte
                        : sel_cnt_hi ? count_high_byte
                        : sel_rld_lo ? reload_low_byte
                        : sel_rld_hi ? reload_high_byte
                        : sel_stat ? irq_stat
                        : sel_mask ? irq_mask
                        : 8'h00;

    // pins and interrupt
    assign count_clockout_pin_out = cko_level;
    assign count_clockout_pin_oe = clockout_enable;
    assign irq = |(irq_stat & irq_mask);

    // input synchronisers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
            pin_level <= 1'b1;
            dir_s1 <= 1'b0;
            dir_s2 <= 1'b0;
            dir_s3 <= 1'b0;
            dir_level <= 1'b0;
        end else begin
            pin_s1 <= count_clockout_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            dir_s1 <= direction_pin;
            dir_s2 <= dir_s1;
            dir_s3 <= dir_s2;
            if (pin_agree) begin
                pin_level <= pin_s3;
            end
            if (dir_agree) begin
                dir_level <= dir_s3;
            end
        end
    end

    // rate dividers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt <= 3'h0;
            cko_cnt <= 2'h0;
        end else begin
            div_cnt <= div6_tick ? 3'h0 : div_cnt + 3'h1;
            cko_cnt <= div2_tick ? 2'h0 : cko_cnt + 2'h1;
        end
    end

    // count and reload registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_low_byte <= tuc_pkg::CNT_RST[7:0];
            count_high_byte <= tuc_pkg::CNT_RST[15:8];
            reload_low_byte <= tuc_pkg::RLD_RST[7:0];
            reload_high_byte <= tuc_pkg::RLD_RST[15:8];
        end else begin
            count_low_byte <= next_lo;
            count_high_byte <= next_hi;
            if (wr_rld_lo) begin
                reload_low_byte <= wdata;
            end
            if (wr_rld_hi) begin
                reload_high_byte <= wdata;
            end
        end
    end

    // control, mode and flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow_flag <= tuc_pkg::CTRL_RST[tuc_pkg::BIT_OVF];
            external_toggle_flag <= tuc_pkg::CTRL_RST[tuc_pkg::BIT_EXT];
            rx_baud <= tuc_pkg::CTRL_RST[tuc_pkg::BIT_RXB];
            tx_baud <= tuc_pkg::CTRL_RST[tuc_pkg::BIT_TXB];
            run_bit <= tuc_pkg::CTRL_RST[tuc_pkg::BIT_RUN];
            count_source_select <= tuc_pkg::CTRL_RST[tuc_pkg::BIT_SRC];
            clockout_enable <= tuc_pkg::MODE_RST[tuc_pkg::BIT_CKO];
            updown_enable <= tuc_pkg::MODE_RST[tuc_pkg::BIT_UPD];
        end else begin
            overflow_flag <= next_ovf;
            external_toggle_flag <= next_ext;
            if (wr_ctrl) begin
                rx_baud <= wdata[tuc_pkg::BIT_RXB];
                tx_baud <= wdata[tuc_pkg::BIT_TXB];
                run_bit <= wdata[tuc_pkg::BIT_RUN];
                count_source_select <= wdata[tuc_pkg::BIT_SRC];
            end
            if (wr_mode) begin
                clockout_enable <= wdata[tuc_pkg::BIT_CKO];
                updown_enable <= wdata[tuc_pkg::BIT_UPD];
            end
        end
    end

    // clock-out level, baud tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cko_level <= 1'b0;
            baud_tick <= 1'b0;
        end else begin
            if (cko_event) begin
                cko_level <= ~cko_level;
            end
            baud_tick <= wrap & baud_mode;
        end
    end

    // interrupt status and mask
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_stat <= tuc_pkg::STAT_RST;
            irq_mask <= tuc_pkg::MASK_RST;
        end else begin
            irq_stat <= next_stat;
            if (wr_mask) begin
                irq_mask <= wdata;
            end
        end
    end

    // read data, one cycle after strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? read_mux : 8'h00;
        end
    end

    // checks
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    timer_div_a: assert property (
        div6_tick |=> !div6_tick [*5] ##1 div6_tick)
        else $error("timer divider not one in six");

    run_hold_a: assert property (
        !run_bit && !any_wr |=> $stable(cnt))
        else $error("count moved while stopped");

    byte_carry_a: assert property (
        step && !count_down && !at_top && !any_wr
        && count_low_byte == 8'hFF
        |=> count_low_byte == 8'h00
        && count_high_byte == $past(count_high_byte) + 8'h01)
        else $error("low byte did not carry");

    up_reload_a: assert property (
        step && !count_down && at_top && !any_wr
        && !clockout_enable && !baud_mode
        |=> cnt == $past(reload) && overflow_flag
        && irq_stat[tuc_pkg::BIT_IRQ_OVF])
        else $error("up overflow mishandled");

    down_wrap_a: assert property (
        step && updown_mode && !dir_level && at_floor && !any_wr
        |=> cnt == tuc_pkg::CNT_MAX && overflow_flag)
        else $error("down underflow mishandled");

    toggle_flag_a: assert property (
        toggle_event && !wr_ctrl
        |=> external_toggle_flag != $past(external_toggle_flag))
        else $error("toggle flag did not flip");

    cko_wrap_a: assert property (
        cko_event && !any_wr
        |=> cko_level != $past(cko_level)
        && overflow_flag == $past(overflow_flag)
        && cnt == $past(reload))
        else $error("clock-out wrap mishandled");

    cko_pin_a: assert property (
        $changed(count_clockout_pin_out)
        |-> $past(cko_event) && $past(count_clockout_pin_oe))
        else $error("clock-out pin not driven");

    stat_set_a: assert property (
        flag_event |=> irq_stat[tuc_pkg::BIT_IRQ_OVF] && overflow_flag)
        else $error("overflow event lost");

    cko_quiet_a: assert property (
        clockout_enable && !wr_ctrl |=> $stable(overflow_flag))
        else $error("flag moved in clock-out mode");

    flag_keep_a: assert property (
        overflow_flag && !wr_ctrl |=> overflow_flag)
        else $error("overflow flag cleared by hardware");

    pin_edge_a: assert property (
        pin_fall |-> !pin_s2 && !pin_s3 && $past(pin_level))
        else $error("pin edge taken unsynchronised");

endmodule : tuc_timer

// ---- tuc_pin_model.sv ----
// far-side model: count pin driver, direction pin, clock-out load
`timescale 1ns/1ps

module tuc_pin_model (
    // clock
    input wire logic clk,
    // pin from the timer
    input wire logic pin_out,
    input wire logic pin_oe,
    // pins to the timer
    output logic pin_in,
    output logic dir_pin
);
    logic drv;

    // pulled-up pin, the timer's driver wins while enabled
    assign pin_in = pin_oe ? pin_out : drv;

    initial begin
        drv = 1'b1;
        dir_pin = 1'b1;
    end

    // one low pulse per count, long enough for the synchroniser
    task pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            drv <= 1'b0;
            repeat (4) @(posedge clk);
            drv <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask : pulse

    task set_dir(input logic up);
        @(posedge clk);
        dir_pin <= up;
        repeat (5) @(posedge clk);
    endtask : set_dir
endmodule : tuc_pin_model

// ---- tuc_tb.sv ----
// self-checking bench for the reload timer with clock output
`timescale 1ns/1ps

module tb;
    logic clk;
    logic rst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic dir_pin;
    logic irq;
    logic baud_tick;
    int n_mismatch;
    int n_checks;
    int cyc;
    int hi;
    int lo;
    logic [7:0] rv;
    logic [15:0] cv;

    tuc_timer tuc_timer_i (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .count_clockout_pin_in(pin_in), .count_clockout_pin_out(pin_out),
        .count_clockout_pin_oe(pin_oe), .direction_pin(dir_pin),
        .irq(irq), .baud_tick(baud_tick));
    tuc_pin_model tuc_pin_model_i (.clk(clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in), .dir_pin(dir_pin));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task wrap_up;
        if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up;
        end
    end

    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask : chk

    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task chk_reg(input string name, input logic [3:0] a, input logic [7:0] e);
        rd_reg(a, rv);
        chk(name, {8'h00, e}, {8'h00, rv});
    endtask : chk_reg

    task set16(input logic [3:0] a, input logic [15:0] v);
        wr_reg(a, v[7:0]);
        wr_reg(a + 4'h1, v[15:8]);
    endtask : set16

    task chk_cnt(input logic [15:0] e);
        rd_reg(tuc_pkg::OFS_CNT_LO, cv[7:0]);
        rd_reg(tuc_pkg::OFS_CNT_HI, cv[15:8]);
        chk("count", e, cv);
    endtask : chk_cnt

    // cycles high then low of one clock-out period
    task meas(output int h, output int l);
        int k;
        k = 0;
        h = 0;
        l = 0;
        while (pin_out !== 1'b0 && k < 50) begin @(posedge clk); k++; end
        while (pin_out !== 1'b1 && k < 100) begin @(posedge clk); k++; end
        while (pin_out === 1'b1 && h < 50) begin @(posedge clk); h++; end
        while (pin_out === 1'b0 && l < 50) begin @(posedge clk); l++; end
    endtask : meas

    initial begin
        n_mismatch = 0;
        n_checks = 0;
        cyc = 0;
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 9; a++) chk_reg("reset", a[3:0], 8'h00);
        wr_reg(4'h9, 8'hFF);
        chk_reg("unmapped", 4'h9, 8'h00);
        // counter mode, up
        wr_reg(tuc_pkg::OFS_IRQ_MASK, 8'h01);
        set16(tuc_pkg::OFS_RLD_LO, 16'h1234);
        set16(tuc_pkg::OFS_CNT_LO, 16'h00FF);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h06);
        tuc_pin_model_i.pulse(1);
        chk_cnt(16'h0100);
        chk("irq_idle", 16'h0000, {15'h0, irq});
        set16(tuc_pkg::OFS_CNT_LO, 16'hFFFF);
        tuc_pin_model_i.pulse(1);
        chk_cnt(16'h1234);
        chk_reg("ctrl_ovf", tuc_pkg::OFS_CTRL, 8'h86);
        chk("irq_set", 16'h0001, {15'h0, irq});
        wr_reg(tuc_pkg::OFS_IRQ_MASK, 8'h00);
        #1 chk("irq_masked", 16'h0000, {15'h0, irq});
        wr_reg(tuc_pkg::OFS_IRQ_MASK, 8'h01);
        #1 chk("irq_unmasked", 16'h0001, {15'h0, irq});
        wr_reg(tuc_pkg::OFS_IRQ_STAT, 8'h01);
        #1 chk("irq_clr", 16'h0000, {15'h0, irq});
        chk_reg("ovf_kept", tuc_pkg::OFS_CTRL, 8'h86);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h02);
        tuc_pin_model_i.pulse(2);
        chk_cnt(16'h1234);
        chk_reg("ovf_sw_clr", tuc_pkg::OFS_CTRL, 8'h02);
        // up/down mode
        wr_reg(tuc_pkg::OFS_MODE, 8'h01);
        tuc_pin_model_i.set_dir(1'b0);
        set16(tuc_pkg::OFS_CNT_LO, 16'h1236);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h06);
        tuc_pin_model_i.pulse(3);
        chk_cnt(16'hFFFF);
        chk_reg("ctrl_dn", tuc_pkg::OFS_CTRL, 8'hC6);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h06);
        tuc_pin_model_i.set_dir(1'b1);
        tuc_pin_model_i.pulse(1);
        chk_cnt(16'h1234);
        chk_reg("ctrl_up", tuc_pkg::OFS_CTRL, 8'hC6);
        // timer mode, clock divided by six
        wr_reg(tuc_pkg::OFS_MODE, 8'h00);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h00);
        set16(tuc_pkg::OFS_CNT_LO, 16'h0000);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h04);
        repeat (60) @(posedge clk);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h00);
        rd_reg(tuc_pkg::OFS_CNT_LO, rv);
        chk("div6", 16'h0001, {15'h0, (rv >= 8'h09 && rv <= 8'h0C)});
        // clock-out setup in order
        wr_reg(tuc_pkg::OFS_IRQ_STAT, 8'h01);
        wr_reg(tuc_pkg::OFS_MODE, 8'h02);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h00);
        set16(tuc_pkg::OFS_RLD_LO, 16'hFFFE);
        set16(tuc_pkg::OFS_CNT_LO, 16'hFFFE);
        wr_reg(tuc_pkg::OFS_CTRL, 8'h04);
        chk("pin_oe", 16'h0001, {15'h0, pin_oe});
        meas(hi, lo);
        chk("cko_high", 16'd4, hi[15:0]);
        chk("cko_low", 16'd4, lo[15:0]);
        chk_reg("cko_ctrl", tuc_pkg::OFS_CTRL, 8'h04);
        chk_reg("cko_stat", tuc_pkg::OFS_IRQ_STAT, 8'h00);
        // baud and clock-out together on one reload pair
        wr_reg(tuc_pkg::OFS_CTRL, 8'h14);
        hi = 0;
        while (baud_tick !== 1'b1 && hi < 40) begin @(posedge clk); hi++; end
        chk("baud_tick", 16'h0001, {15'h0, baud_tick});
        meas(hi, lo);
        chk("cko_baud", 16'd4, hi[15:0]);
        // second reset while clock-out runs
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("rst_oe", 16'h0000, {15'h0, pin_oe});
        chk("rst_pin", 16'h0000, {15'h0, pin_out});
        chk_reg("rst_mode", tuc_pkg::OFS_MODE, 8'h00);
        chk_reg("rst_ctrl", tuc_pkg::OFS_CTRL, 8'h00);
        chk_cnt(16'h0000);
        wrap_up;
    end
endmodule : tb
